// File: hw/rpm_pkg.sv
package rpm_pkg;
    localparam logic [7:0] power_control_addr = 8'h87;
    localparam logic [7:0] flash_memory_control_addr = 8'hee;
    localparam logic [7:0] peripheral_power_down_addr = 8'hf1;
    localparam logic [7:0] system_reset_trigger_addr = 8'hf7;
    localparam logic [7:0] watchdog_control_addr = 8'hff;
    // power_control field positions
    localparam int pc_idle_bit = 0;
    localparam int pc_stop_bit = 1;
    // system_reset_trigger: bit 0 must be written 1 to fire a software reset
    localparam int srt_fire_bit = 0;
    // watchdog_control: bit 7 arms, bits 6:0 reload value, writing 8'ha5 kicks
    localparam int wd_arm_bit = 7;
    localparam logic [7:0] wd_kick_value = 8'ha5;
    // flash_memory_control: bit 0 selects the delay line
    localparam int fmc_delay_bit = 0;
    // hw_config_word_a fields
    localparam int cfga_wd_en_bit = 3;
    localparam int cfga_lock_lo = 4;
    localparam int cfga_lock_all = 5;
    localparam int cfga_part_lsb = 0;
    // hw_config_word_b fields
    localparam int cfgb_bor_en_bit = 1;
    localparam logic [7:0] power_control_rst = 8'h00;
    localparam logic [7:0] peripheral_power_down_rst = 8'h00;
    localparam logic [7:0] watchdog_control_rst = 8'h00;
    localparam logic [7:0] flash_memory_control_rst = 8'h00;
    // reset stretch counts
    localparam int long_reset_log2 = 17;
    localparam int short_reset_log2 = 15;
    localparam int wd_prescale_log2 = 10;
    localparam logic [15:0] flash_lock_low_top = 16'h0fff;
    localparam logic [15:0] sram_alt_base = 16'h8400;
    localparam logic [15:0] sram_size = 16'h0400;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rpm_sfr_req_s;
    typedef enum logic [1:0] {
        rpm_run,
        rpm_idle,
        rpm_stop
    } rpm_mode_e;
endpackage

// File: hw/rpm_reset_power.sv
`timescale 1ns/1ps
module rpm_reset_power #(
    parameter int long_log2 = rpm_pkg::long_reset_log2,
    parameter int short_log2 = rpm_pkg::short_reset_log2,
    parameter int pin_width = 32,
    parameter int wd_pre_log2 = rpm_pkg::wd_prescale_log2
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic reset_pin,
    input wire logic supply_low,
    input wire logic analog_supply_good,
    input wire logic programming_mode,
    input wire logic [7:0] hw_config_word_a,
    input wire logic [7:0] hw_config_word_b,
    input wire rpm_pkg::rpm_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic irq_pending,
    input wire logic [pin_width-1:0] pin_out_core,
    output logic [pin_width-1:0] pin_out,
    output logic internal_reset,
    output logic osc_enable,
    output logic cpu_clk_en,
    output logic timer01_clk_en,
    output logic serial_clk_en,
    output logic periph_clk_en,
    output logic [7:0] periph_power_down,
    output logic bor_calibrated,
    output logic flash_delay_line,
    input wire logic [15:0] flash_wr_addr,
    input wire logic flash_wr_req,
    output logic flash_wr_allow,
    input wire logic [15:0] fetch_addr,
    output logic fetch_from_sram,
    output logic fetch_from_flash,
    output logic fetch_external,
    input wire logic sram_relocate,
    input wire logic [15:0] data_addr,
    output logic data_to_sram,
    input wire logic [2:0] clk_div_sel,
    output logic sys_clk_en,
    output logic conv_clk_en
);
    initial begin
        if (long_log2 < short_log2 || pin_width < 1) begin
            $error("rpm_reset_power: bad parameters");
        end
    end
    // pin inputs pass two flops; the first stage is read only by the second
    logic [2:0] sync1_r, sync2_r;
    logic pin_prev_r;
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            pin_prev_r <= 1'b0;
        end else begin
            sync1_r <= {analog_supply_good, supply_low, reset_pin};
            sync2_r <= sync1_r;
            pin_prev_r <= sync2_r[0];
        end
    end
    wire pin_hi = sync2_r[0];
    wire pin_fall = pin_prev_r & ~pin_hi;
    wire low_s = sync2_r[1];
    wire agood_s = sync2_r[2];
    wire bor_en = hw_config_word_b[rpm_pkg::cfgb_bor_en_bit];
    wire wd_en = hw_config_word_a[rpm_pkg::cfga_wd_en_bit];
    // register file
    logic [7:0] power_control_r, pdn_r, wdc_r, fmc_r;
    rpm_pkg::rpm_mode_e mode_r;
    logic low_prev_r;
    wire wr_pc = sfr_req.wr && sfr_req.addr == rpm_pkg::power_control_addr;
    wire wr_pd = sfr_req.wr && sfr_req.addr == rpm_pkg::peripheral_power_down_addr;
    wire wr_srt = sfr_req.wr && sfr_req.addr == rpm_pkg::system_reset_trigger_addr;
    wire wr_wd = sfr_req.wr && sfr_req.addr == rpm_pkg::watchdog_control_addr;
    wire wr_fm = sfr_req.wr && sfr_req.addr == rpm_pkg::flash_memory_control_addr;
    wire sw_fire = wr_srt && sfr_req.wdata[rpm_pkg::srt_fire_bit];
    wire wd_kick = wr_wd && sfr_req.wdata == rpm_pkg::wd_kick_value;
    // watchdog: prescaler plus 7-bit down count from reload, armed in wdc
    logic [wd_pre_log2-1:0] wd_pre_r;
    logic [6:0] wd_cnt_r;
    wire wd_armed = wd_en && wdc_r[rpm_pkg::wd_arm_bit];
    wire wd_tick = &wd_pre_r;
    wire wd_fire = wd_armed && wd_tick && wd_cnt_r == 7'h00 && !wd_kick;
    // brownout: freeze while low, reset on rising back above
    wire bor_low = bor_en && low_s;
    wire bor_rise = bor_en && low_prev_r && !low_s;
    wire in_stop = mode_r == rpm_pkg::rpm_stop;
    // stop may only be left by pin or power-on reset
    wire long_start = pin_fall || (!in_stop && (sw_fire || wd_fire));
    wire short_start = !in_stop && bor_rise;
    logic long_busy, short_busy;
    rpm_stretch #(.count_log2(long_log2)) u_long (
        .clock(clock),
        .rst(rst),
        .start(long_start),
        .hold(pin_hi),
        .busy(long_busy)
    );
    rpm_stretch #(.count_log2(short_log2)) u_short (
        .clock(clock),
        .rst(rst),
        .start(short_start),
        .hold(!agood_s),
        .busy(short_busy)
    );
    wire in_reset = long_busy || short_busy || long_start || short_start;
    logic [pin_width-1:0] pin_hold_r;
    logic cal_r;
    always_ff @(posedge clock) begin
        if (rst || in_reset) begin
            power_control_r <= rpm_pkg::power_control_rst;
            pdn_r <= rpm_pkg::peripheral_power_down_rst;
            wdc_r <= rpm_pkg::watchdog_control_rst;
            fmc_r <= rpm_pkg::flash_memory_control_rst;
            mode_r <= rpm_pkg::rpm_run;
        end else if (!in_stop && !bor_low) begin
            if (wr_pc) begin
                power_control_r <= sfr_req.wdata;
            end
            if (wr_pd) begin
                pdn_r <= sfr_req.wdata;
            end
            if (wr_wd && !wd_kick) begin
                wdc_r <= sfr_req.wdata;
            end
            if (wr_fm) begin
                fmc_r <= sfr_req.wdata;
            end
            unique case (mode_r)
                rpm_pkg::rpm_run: begin
                    if (wr_pc && sfr_req.wdata[rpm_pkg::pc_stop_bit]) begin
                        mode_r <= rpm_pkg::rpm_stop;
                    end else if (wr_pc && sfr_req.wdata[rpm_pkg::pc_idle_bit]) begin
                        mode_r <= rpm_pkg::rpm_idle;
                    end
                end
                rpm_pkg::rpm_idle: begin
                    if (irq_pending) begin
                        mode_r <= rpm_pkg::rpm_run;
                        power_control_r[rpm_pkg::pc_idle_bit] <= 1'b0;
                    end
                end
                rpm_pkg::rpm_stop: begin
                    mode_r <= rpm_pkg::rpm_stop;
                end
                default: mode_r <= rpm_pkg::rpm_run;
            endcase
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            low_prev_r <= 1'b0;
            wd_pre_r <= '0;
            wd_cnt_r <= 7'h7f;
            cal_r <= 1'b0;
            pin_hold_r <= '1;
        end else begin
            low_prev_r <= bor_en && low_s;
            // calibration only valid once a reset cycle has ended
            cal_r <= in_reset ? 1'b0 : 1'b1;
            if (!in_stop) begin
                pin_hold_r <= in_reset ? '1 : pin_out_core;
            end
            if (in_reset || wd_kick || !wd_armed) begin
                wd_pre_r <= '0;
                wd_cnt_r <= wdc_r[6:0];
            end else if (!in_stop && !bor_low) begin
                wd_pre_r <= wd_pre_r + 1'b1;
                if (wd_tick && wd_cnt_r != 7'h00) begin
                    wd_cnt_r <= wd_cnt_r - 7'h01;
                end
            end
        end
    end
    // clock divider shared by system and converter clock enables
    logic [6:0] div_cnt_r;
    logic div_pulse_r;
    wire [6:0] div_top = 7'((7'h01 << clk_div_sel) - 7'h01);
    always_ff @(posedge clock) begin
        if (rst || in_reset) begin
            div_cnt_r <= 7'h00;
            div_pulse_r <= 1'b0;
        end else begin
            div_pulse_r <= div_cnt_r == div_top;
            div_cnt_r <= (div_cnt_r >= div_top) ? 7'h00 : div_cnt_r + 7'h01;
        end
    end
    wire run_ok = !in_reset && !in_stop && !bor_low;
    assign sys_clk_en = run_ok && div_pulse_r;
    assign conv_clk_en = sys_clk_en;
    assign cpu_clk_en = sys_clk_en && mode_r != rpm_pkg::rpm_idle;
    assign timer01_clk_en = cpu_clk_en;
    assign serial_clk_en = cpu_clk_en;
    assign periph_clk_en = sys_clk_en;
    assign periph_power_down = pdn_r;
    assign osc_enable = !pin_hi && !in_stop;
    assign internal_reset = in_reset;
    assign pin_out = (in_reset || pin_hi) ? '1 : pin_hold_r;
    assign bor_calibrated = cal_r;
    assign flash_delay_line = fmc_r[rpm_pkg::fmc_delay_bit];
    // flash partition: 3-bit select picks program top from a table, 16K to 32K, or none for selects 0 and 1
    wire [2:0] part_sel = hw_config_word_a[rpm_pkg::cfga_part_lsb +: 3];
    wire [15:0] prog_top = part_sel == 3'h7 ? 16'h8000 :
                           part_sel == 3'h6 ? 16'h7c00 :
                           part_sel == 3'h5 ? 16'h7800 :
                           part_sel == 3'h4 ? 16'h7000 :
                           part_sel == 3'h3 ? 16'h6000 :
                           part_sel == 3'h2 ? 16'h4000 : 16'h0000;
    wire lock_lo = !hw_config_word_a[rpm_pkg::cfga_lock_lo];
    wire lock_all = !hw_config_word_a[rpm_pkg::cfga_lock_all];
    wire in_prog = flash_wr_addr < prog_top;
    assign flash_wr_allow = flash_wr_req && (programming_mode || !(in_prog &&
        (lock_all || (lock_lo && flash_wr_addr <= rpm_pkg::flash_lock_low_top))));
    wire fetch_sram = sram_relocate && fetch_addr >= rpm_pkg::sram_alt_base &&
        fetch_addr < 16'(rpm_pkg::sram_alt_base + rpm_pkg::sram_size);
    assign fetch_from_sram = fetch_sram;
    assign fetch_from_flash = !fetch_sram && fetch_addr < prog_top;
    assign fetch_external = !fetch_sram && fetch_addr >= prog_top;
    wire [15:0] sram_base = sram_relocate ? rpm_pkg::sram_alt_base : 16'h0000;
    assign data_to_sram = data_addr >= sram_base &&
        data_addr < 16'(sram_base + rpm_pkg::sram_size);
    // undefined addresses read zero; software should not rely on it
    logic [7:0] rdata_r;
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (sfr_req.rd) begin
            unique case (sfr_req.addr)
                rpm_pkg::power_control_addr: rdata_r <= power_control_r;
                rpm_pkg::peripheral_power_down_addr: rdata_r <= pdn_r;
                rpm_pkg::watchdog_control_addr: rdata_r <= {wdc_r[7], wd_cnt_r};
                rpm_pkg::flash_memory_control_addr: rdata_r <= fmc_r;
                default: rdata_r <= 8'h00;
            endcase
        end
    end
    assign sfr_rdata = rdata_r;

    pin_reset_a: assert property (@(posedge clock) disable iff (rst)
        in_reset |-> pin_out == '1) else $error("pins not high in reset");
    stretch_hold_a: assert property (@(posedge clock) disable iff (rst)
        $rose(long_start) |=> internal_reset [*8]) else $error("reset short");
    stop_clk_a: assert property (@(posedge clock) disable iff (rst)
        in_stop |-> !sys_clk_en && !osc_enable) else $error("clock in stop");
    idle_cpu_a: assert property (@(posedge clock) disable iff (rst)
        mode_r == rpm_pkg::rpm_idle |-> !cpu_clk_en) else $error("cpu runs idle");
    idle_wake_a: assert property (@(posedge clock) disable iff (rst)
        mode_r == rpm_pkg::rpm_idle && irq_pending && !in_reset && !bor_low
        |=> mode_r != rpm_pkg::rpm_idle) else $error("idle not left");
    stop_wake_a: assert property (@(posedge clock) disable iff (rst)
        in_stop && !pin_fall && !long_busy && !short_busy |=> in_stop || internal_reset)
        else $error("stop left wrongly");
    stop_pins_a: assert property (@(posedge clock) disable iff (rst)
        in_stop && $past(in_stop) && !in_reset && !pin_hi |-> $stable(pin_out))
        else $error("pins moved in stop");
    conv_div_a: assert property (@(posedge clock) disable iff (rst)
        conv_clk_en == sys_clk_en) else $error("converter clock undivided");
    sw_reset_a: assert property (@(posedge clock) disable iff (rst)
        sw_fire && !in_stop |-> internal_reset ##1 internal_reset)
        else $error("software reset missed");
    cal_wait_a: assert property (@(posedge clock) disable iff (rst)
        in_reset |=> !bor_calibrated) else $error("calibrated early");
    bor_freeze_a: assert property (@(posedge clock) disable iff (rst)
        bor_low && !in_reset |=> $stable(pdn_r) && $stable(mode_r))
        else $error("state moved in brownout");
    bor_hold_a: assert property (@(posedge clock) disable iff (rst)
        short_start |=> internal_reset [*8])
        else $error("brownout reset short");
    wd_reset_a: assert property (@(posedge clock) disable iff (rst)
        wd_fire && !in_stop |-> internal_reset ##1 internal_reset)
        else $error("watchdog reset missed");
    cov_idle_c: cover property (@(posedge clock) mode_r == rpm_pkg::rpm_idle ##1
        mode_r == rpm_pkg::rpm_run);
    cov_stop_c: cover property (@(posedge clock) $rose(in_stop));
    cov_pin_c: cover property (@(posedge clock) pin_fall);
    cov_bor_c: cover property (@(posedge clock) short_start);
endmodule

// File: hw/rpm_stretch.sv
`timescale 1ns/1ps
module rpm_stretch #(
    parameter int count_log2 = 17
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic hold,
    output logic busy
);
    initial begin
        if (count_log2 < 2 || count_log2 > 24) begin
            $error("rpm_stretch: count_log2 out of range");
        end
    end
    logic [count_log2-1:0] cnt_r;
    logic busy_r;
    // hold keeps the count at its start value while the source stays asserted
    always_ff @(posedge clock) begin
        if (rst) begin
            busy_r <= 1'b1;
            cnt_r <= '0;
        end else if (start || hold) begin
            busy_r <= 1'b1;
            cnt_r <= '0;
        end else if (busy_r) begin
            cnt_r <= cnt_r + 1'b1;
            if (&cnt_r) begin
                busy_r <= 1'b0;
            end
        end
    end
    assign busy = busy_r;
endmodule

// File: testbench/rpm_reset_power_tb_top.sv
`timescale 1ns/1ps
module rpm_reset_power_tb_top;
    localparam int lg = 6;
    localparam int sh = 4;
    logic clock = 1'b0, rst = 1'b1, programming_mode = 1'b0, irq_pending = 1'b0;
    logic flash_wr_req = 1'b1, sram_relocate = 1'b0, reset_pin, supply_low, analog_supply_good;
    logic internal_reset, osc_enable, cpu_clk_en, timer01_clk_en, serial_clk_en, periph_clk_en;
    logic bor_calibrated, flash_delay_line, flash_wr_allow, fetch_from_sram, fetch_from_flash;
    logic fetch_external, data_to_sram, sys_clk_en, conv_clk_en;
    logic [7:0] hw_config_word_a = 8'h37, hw_config_word_b = 8'h00, pin_out_core = 8'h00;
    logic [7:0] sfr_rdata, pin_out, periph_power_down;
    logic [15:0] flash_wr_addr = 16'h0000, fetch_addr = 16'h0000, data_addr = 16'h0000;
    logic [2:0] clk_div_sel = 3'h0;
    rpm_pkg::rpm_sfr_req_s sfr_req = '0;
    int bad_count = 0;
    int n_tests = 0;
    int pc[6];
    rpm_reset_power #(.long_log2(lg), .short_log2(sh), .pin_width(8), .wd_pre_log2(2)) dut (
        .clock, .rst, .reset_pin, .supply_low, .analog_supply_good, .programming_mode,
        .hw_config_word_a, .hw_config_word_b, .sfr_req, .sfr_rdata, .irq_pending,
        .pin_out_core, .pin_out, .internal_reset, .osc_enable, .cpu_clk_en, .timer01_clk_en,
        .serial_clk_en, .periph_clk_en, .periph_power_down, .bor_calibrated, .flash_delay_line,
        .flash_wr_addr, .flash_wr_req, .flash_wr_allow, .fetch_addr, .fetch_from_sram,
        .fetch_from_flash, .fetch_external, .sram_relocate, .data_addr, .data_to_sram,
        .clk_div_sel, .sys_clk_en, .conv_clk_en);
    rpm_supply_model model (.clock, .reset_pin, .supply_low, .analog_supply_good);
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock) sfr_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock) sfr_req <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock) sfr_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock) sfr_req <= '0;
        #1;
        d = sfr_rdata;
    endtask
    // counts enable pulses per clock output over n cycles
    task automatic pulses(input int n);
        logic [5:0] en;
        pc = '{default: 0};
        repeat (n) begin
            tick(1);
            en = {conv_clk_en, sys_clk_en, periph_clk_en, serial_clk_en, timer01_clk_en,
                cpu_clk_en};
            for (int i = 0; i < 6; i++) pc[i] += en[i];
        end
    endtask
    task automatic wait_hi(input int hi);
        int n;
        n = 0;
        while (internal_reset !== 1'b1 && n <= hi) begin
            tick(1);
            n++;
        end
        chk("reset start", n <= hi, 1);
        if (n > hi) results();
    endtask
    task automatic span(input string what, input int lo, input int hi);
        int n;
        n = 0;
        while (internal_reset === 1'b1 && n <= hi) begin
            tick(1);
            n++;
        end
        chk(what, n >= lo && n <= hi, 1);
        if (n > hi) results();
    endtask
    task automatic t_regs();
        logic [7:0] d;
        logic [7:0] ra[4] = '{8'h87, 8'hf1, 8'hff, 8'hee};
        foreach (ra[i]) begin
            rd(ra[i], d);
            chk("reset value", d, 8'h00);
        end
        rd(8'hf7, d);
        chk("trigger read", d, 8'h00);
        wr(8'hf1, 8'hff);
        chk("all down", periph_power_down, 8'hff);
        wr(8'hf1, 8'h5a);
        rd(8'hf1, d);
        chk("power down bits", {d, periph_power_down}, 16'h5a5a);
        wr(8'hf1, 8'h00);
        wr(8'hee, 8'h01);
        chk("delay line", flash_delay_line, 1'b1);
    endtask
    task automatic t_mem();
        // cfg, programming, address, allowed
        logic [25:0] lk[5] = '{{8'h27, 1'h0, 16'h0800, 1'h0}, {8'h27, 1'h0, 16'h1000, 1'h1},
            {8'h17, 1'h0, 16'h1000, 1'h0}, {8'h17, 1'h1, 16'h1000, 1'h1},
            {8'h37, 1'h0, 16'h0000, 1'h1}};
        // partition, relocate, address, sram flash external data_sram
        logic [23:0] fr[8] = '{{3'h7, 1'h0, 16'h7fff, 4'h4}, {3'h7, 1'h0, 16'h8000, 4'h2},
            {3'h6, 1'h0, 16'h7c00, 4'h2}, {3'h6, 1'h0, 16'h7bff, 4'h4},
            {3'h0, 1'h0, 16'h0000, 4'h3}, {3'h7, 1'h1, 16'h8400, 4'h9},
            {3'h7, 1'h1, 16'h8800, 4'h2}, {3'h2, 1'h0, 16'h4000, 4'h2}};
        foreach (lk[i]) begin
            @(posedge clock) begin
                hw_config_word_a <= lk[i][25:18];
                programming_mode <= lk[i][17];
                flash_wr_addr <= lk[i][16:1];
            end
            tick(1);
            chk("flash lock", flash_wr_allow, lk[i][0]);
        end
        @(posedge clock) flash_wr_req <= 1'b0;
        tick(1);
        chk("no flash request", flash_wr_allow, 1'b0);
        @(posedge clock) flash_wr_req <= 1'b1;
        foreach (fr[i]) begin
            @(posedge clock) begin
                hw_config_word_a <= {5'h06, fr[i][23:21]};
                sram_relocate <= fr[i][20];
                fetch_addr <= fr[i][19:4];
                data_addr <= fr[i][19:4];
            end
            tick(1);
            chk("routing", {fetch_from_sram, fetch_from_flash, fetch_external, data_to_sram},
                fr[i][3:0]);
        end
        @(posedge clock) hw_config_word_a <= 8'h37;
        @(posedge clock) clk_div_sel <= 3'h2;
        pulses(16);
        chk("sys divided", pc[4], 4);
        chk("conv divided", pc[5], 4);
        @(posedge clock) clk_div_sel <= 3'h0;
    endtask
    task automatic t_idle();
        wr(8'h87, 8'h01);
        tick(2);
        pulses(16);
        chk("idle cpu", pc[0], 0);
        chk("idle timers", pc[1], 0);
        chk("idle serial", pc[2], 0);
        chk("idle periph", pc[3] > 0, 1);
        @(posedge clock) irq_pending <= 1'b1;
        tick(3);
        @(posedge clock) irq_pending <= 1'b0;
        pulses(8);
        chk("woken cpu", pc[0] > 0, 1);
    endtask
    task automatic t_soft();
        wr(8'hf7, 8'h01);
        chk("soft reset", internal_reset, 1'b1);
        tick(40);
        chk("pins high", pin_out, 8'hff);
        chk("uncalibrated", bor_calibrated, 1'b0);
        wr(8'hf7, 8'h01);
        span("restarted stretch", 2 ** lg - 4, 2 ** lg + 4);
    endtask
    task automatic t_pin();
        fork
            model.pin_reset(20);
            begin
                tick(4);
                chk("osc halted", osc_enable, 1'b0);
                chk("pin held", {internal_reset, pin_out}, 9'h1ff);
            end
        join
        #1;
        span("pin stretch", 2 ** lg, 2 ** lg + 7);
    endtask
    task automatic t_wd();
        @(posedge clock) hw_config_word_a <= 8'h3f;
        wr(8'hff, 8'h03);
        tick(60);
        chk("wd unarmed", internal_reset, 1'b0);
        wr(8'hff, 8'h83);
        repeat (4) begin
            tick(6);
            wr(8'hff, 8'ha5);
        end
        chk("wd kicked", internal_reset, 1'b0);
        wait_hi(60);
        span("wd stretch", 2 ** lg - 4, 2 ** lg + 4);
        @(posedge clock) hw_config_word_a <= 8'h37;
        wr(8'hff, 8'h83);
        tick(60);
        chk("wd disabled", internal_reset, 1'b0);
        wr(8'hff, 8'h00);
    endtask
    task automatic t_stop();
        @(posedge clock) pin_out_core <= 8'h3c;
        tick(3);
        chk("run pins", pin_out, 8'h3c);
        wr(8'h87, 8'h02);
        @(posedge clock) pin_out_core <= 8'hc3;
        @(posedge clock) irq_pending <= 1'b1;
        wr(8'hf7, 8'h01);
        pulses(16);
        chk("stop pins", pin_out, 8'h3c);
        chk("stop clocks", pc[0] + pc[3] + pc[4], 0);
        chk("stop no wake", internal_reset, 1'b0);
        @(posedge clock) irq_pending <= 1'b0;
        model.pin_reset(4);
        #1;
        span("stop exit", 2 ** lg, 2 ** lg + 7);
        pulses(4);
        chk("resumed", pc[0] > 0, 1);
    endtask
    task automatic t_bor();
        model.dip(8);
        tick(4);
        chk("bor disabled", internal_reset, 1'b0);
        @(posedge clock) hw_config_word_b <= 8'h02;
        model.dip(8);
        #1;
        wait_hi(6);
        span("bor stretch", 2 ** sh - 4, 2 ** sh + 6);
        model.analog(1'b0);
        tick(40);
        chk("analog hold", internal_reset, 1'b1);
        model.analog(1'b1);
        #1;
        span("analog release", 2 ** sh - 4, 2 ** sh + 6);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        tick(1);
        chk("pins in reset", pin_out, 8'hff);
        span("power-up stretch", 2 ** lg - 4, 2 ** lg + 4);
        tick(1);
        chk("calibrated", bor_calibrated, 1'b1);
        t_regs();
        t_mem();
        t_idle();
        t_soft();
        t_pin();
        t_wd();
        t_stop();
        t_bor();
        results();
    end
endmodule

// File: testbench/rpm_supply_model.sv
`timescale 1ns/1ps
module rpm_supply_model (
    input wire logic clock,
    output logic reset_pin,
    output logic supply_low,
    output logic analog_supply_good
);
    initial begin
        reset_pin = 1'b0;
        supply_low = 1'b0;
        analog_supply_good = 1'b1;
    end
    // the pin is never released before two whole clock periods have passed
    task automatic pin_reset(input int n);
        @(posedge clock) reset_pin <= 1'b1;
        repeat ((n < 2) ? 2 : n) @(posedge clock);
        reset_pin <= 1'b0;
    endtask
    task automatic dip(input int n);
        @(posedge clock) supply_low <= 1'b1;
        repeat (n) @(posedge clock);
        supply_low <= 1'b0;
    endtask
    task automatic analog(input logic good);
        @(posedge clock) analog_supply_good <= good;
    endtask
endmodule
